// ---- verilog/sw_master_map.svh ----
`ifndef SW_MASTER_MAP_SVH
`define SW_MASTER_MAP_SVH
`define CLK_MHZ 10
`define RESET_LOW_US 480
`define RESET_LOW_CYC (`RESET_LOW_US * `CLK_MHZ)
`define PRES_WAIT_MAX_US 60
`define PRES_LOW_MAX_US 240
`define PRES_WIN_US 300
`define PRES_WIN_CYC (`PRES_WIN_US * `CLK_MHZ)
`define PRES_SAMPLE_US 70
`define PRES_SAMPLE_CYC (`PRES_SAMPLE_US * `CLK_MHZ)
`define SLOT_US 70
`define SLOT_CYC (`SLOT_US * `CLK_MHZ)
`define REC_US 2
`define REC_CYC (`REC_US * `CLK_MHZ)
`define LOW1_US 6
`define LOW1_CYC (`LOW1_US * `CLK_MHZ)
`define LOW0_US 65
`define LOW0_CYC (`LOW0_US * `CLK_MHZ)
`define RD_SAMPLE_US 12
`define RD_SAMPLE_CYC (`RD_SAMPLE_US * `CLK_MHZ)
`define CMD_READ_ID 8'h33
`define CMD_READ_ID_OLD 8'h0f
`define CMD_SELECT 8'h55
`define CMD_SKIP 8'hcc
`define CMD_SEARCH 8'hf0
`define CRC_POLY_REV 8'h8c
`define ID_BITS 64
`define FIFO_DEPTH 32
`define FIFO_WIDTH 8
`endif

// ---- verilog/sw_master_pkg.sv ----
package sw_master_pkg;
  typedef enum logic [1:0] {
    OP_READ_ID = 2'h0,
    OP_SEARCH = 2'h1,
    OP_SKIP = 2'h2,
    OP_RESET_ONLY = 2'h3
  } op_t;
  typedef logic [7:0] byte_t;
endpackage

// ---- verilog/sw_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_r <= '0;
        rp_r <= '0;
        cnt_r <= '0;
      end else begin
        if (push) wp_r <= wp_r + 1'b1;
        if (pop) rp_r <= rp_r + 1'b1;
        if (push && !pop) cnt_r <= cnt_r + 1'b1;
        else if (pop && !push) cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // sw_fifo
`default_nettype wire

// ---- verilog/sw_master.sv ----
// Function
// - all bits shifted least significant first
// - master releases line high during pauses
// - reset pulse then presence pulse
// - init, rom command, then data read
// - rom command is exactly eight bits
// - read-id only with single slave attached
// - search: bit, complement, master writes choice
// - master starts every slot except presence
// - reset low at least 480us, then release
// - bit rate at most 16.3 kbit/s
// - each slot starts with master falling edge
// - crc over family and serial only
// - crc poly x8+x5+x4+1, zero start, lsb first
`include "sw_master_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sw_master (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire sw_master_pkg::op_t op,
  input wire logic [63:0] search_path,
  output logic busy,
  output logic done_r,
  output logic presence_r,
  output logic crc_ok_r,
  output logic [63:0] id_r,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe
);
  import sw_master_pkg::*;
  // ==========================================================
  // crc
  function automatic byte_t crc_step(input byte_t c, input logic b);
    byte_t n;
    n = c >> 1;
    if (c[0] ^ b) n = n ^ `CRC_POLY_REV;
    return n;
  endfunction
  // ==========================================================
  // state
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_RST_LOW = 9'h002,
    S_PRES = 9'h004,
    S_CMD = 9'h008,
    S_READ = 9'h010,
    S_SRCH_A = 9'h020,
    S_SRCH_B = 9'h040,
    S_SRCH_W = 9'h080,
    S_DONE = 9'h100
  } state_t;
  typedef enum logic [1:0] {
    K_W0 = 2'h0,
    K_W1 = 2'h1,
    K_RD = 2'h2
  } slot_t;
  state_t state_r;
  op_t op_r;
  logic [15:0] tmr_r;
  logic [6:0] bit_r;
  logic [7:0] cmd_r;
  logic [63:0] path_r;
  byte_t crc_r;
  logic first_r;
  logic slot_go_r;
  slot_t slot_kind_r;
  logic slot_busy_r;
  logic [15:0] slot_t_r;
  logic slot_smp_r;
  logic slot_done;
  logic pres_seen_r;
  logic bit_a_r;
  logic pull_r;
  logic fifo_ready;
  logic [7:0] byte_sr_r;
  logic push_r;
  logic stall;
  logic cur_bit;
  assign busy = (state_r != S_IDLE);
  assign line_out = 1'b0;
  assign line_oe = pull_r;
  assign stall = push_r && !fifo_ready;
  assign slot_done = slot_busy_r && (slot_t_r == 16'(`SLOT_CYC + `REC_CYC - 1));
  // ==========================================================
  // slot engine: master always opens the slot by pulling low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slot_busy_r <= 1'b0;
      slot_t_r <= '0;
      slot_smp_r <= 1'b0;
    end else if (ce) begin
      if (slot_go_r && !slot_busy_r && !stall) begin
        slot_busy_r <= 1'b1;
        slot_t_r <= '0;
      end else if (slot_busy_r) begin
        slot_t_r <= slot_t_r + 16'h0001;
        if (slot_t_r == 16'(`RD_SAMPLE_CYC)) slot_smp_r <= line_in;
        if (slot_done) slot_busy_r <= 1'b0;
      end
    end
  end
  // pull low only; pullup makes the high level, slots spaced to 72us
  always_comb begin
    pull_r = 1'b0;
    if (state_r == S_RST_LOW) pull_r = 1'b1;
    else if (slot_busy_r) begin
      unique case (slot_kind_r)
        K_W0: pull_r = (slot_t_r < 16'(`LOW0_CYC));
        K_W1: pull_r = (slot_t_r < 16'(`LOW1_CYC));
        K_RD: pull_r = (slot_t_r < 16'(`CLK_MHZ));
        default: pull_r = 1'b0;
      endcase
    end
  end
  // ==========================================================
  // transaction sequencer
  always_comb begin
    unique case (state_r)
      S_CMD: cur_bit = cmd_r[bit_r[2:0]];
      S_SRCH_W: cur_bit = path_r[bit_r[5:0]];
      default: cur_bit = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      op_r <= OP_RESET_ONLY;
      tmr_r <= '0;
      bit_r <= '0;
      cmd_r <= '0;
      path_r <= '0;
      slot_go_r <= 1'b0;
      slot_kind_r <= K_RD;
      first_r <= 1'b0;
      pres_seen_r <= 1'b0;
      bit_a_r <= 1'b0;
      done_r <= 1'b0;
      presence_r <= 1'b0;
    end else if (ce && !stall) begin
      slot_go_r <= 1'b0;
      done_r <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (start) begin
            op_r <= op;
            path_r <= search_path;
            state_r <= S_RST_LOW;
            tmr_r <= '0;
          end
        end
        S_RST_LOW: begin
          tmr_r <= tmr_r + 16'h0001;
          if (tmr_r == 16'(`RESET_LOW_CYC - 1)) begin
            state_r <= S_PRES;
            tmr_r <= '0;
            pres_seen_r <= 1'b0;
          end
        end
        S_PRES: begin
          tmr_r <= tmr_r + 16'h0001;
          if (tmr_r == 16'(`PRES_SAMPLE_CYC) && !line_in) pres_seen_r <= 1'b1;
          if (tmr_r == 16'(`PRES_WIN_CYC - 1)) begin
            presence_r <= pres_seen_r;
            bit_r <= '0;
            first_r <= 1'b1;
            unique case (op_r)
              OP_READ_ID: cmd_r <= `CMD_READ_ID;
              OP_SEARCH: cmd_r <= `CMD_SEARCH;
              OP_SKIP: cmd_r <= `CMD_SKIP;
              default: cmd_r <= '0;
            endcase
            if (pres_seen_r && op_r != OP_RESET_ONLY) state_r <= S_CMD;
            else state_r <= S_DONE;
          end
        end
        S_CMD: begin
          if (first_r || slot_done) begin
            if (!first_r && bit_r == 7'd7) begin
              bit_r <= '0;
              first_r <= 1'b1;
              unique case (op_r)
                OP_READ_ID: state_r <= S_READ;
                OP_SEARCH: state_r <= S_SRCH_A;
                default: state_r <= S_DONE;
              endcase
            end else begin
              if (!first_r) bit_r <= bit_r + 7'd1;
              first_r <= 1'b0;
              slot_go_r <= 1'b1;
              slot_kind_r <= cmd_r[first_r ? 3'd0 : 3'(bit_r + 7'd1)] ? K_W1 : K_W0;
            end
          end
        end
        S_READ: begin
          if (first_r || slot_done) begin
            if (!first_r) bit_r <= bit_r + 7'd1;
            first_r <= 1'b0;
            if (!first_r && bit_r == 7'(`ID_BITS - 1)) state_r <= S_DONE;
            else begin
              slot_go_r <= 1'b1;
              slot_kind_r <= K_RD;
            end
          end
        end
        S_SRCH_A: begin
          if (first_r) begin
            first_r <= 1'b0;
            slot_go_r <= 1'b1;
            slot_kind_r <= K_RD;
          end else if (slot_done) begin
            bit_a_r <= slot_smp_r;
            state_r <= S_SRCH_B;
            slot_go_r <= 1'b1;
          end
        end
        S_SRCH_B: begin
          if (slot_done) begin
            // both high: no slave left on the bus
            if (bit_a_r && slot_smp_r) state_r <= S_DONE;
            else begin
              if (bit_a_r != slot_smp_r) path_r[bit_r[5:0]] <= bit_a_r;
              state_r <= S_SRCH_W;
              first_r <= 1'b1;
            end
          end
        end
        S_SRCH_W: begin
          if (first_r) begin
            first_r <= 1'b0;
            slot_go_r <= 1'b1;
            slot_kind_r <= cur_bit ? K_W1 : K_W0;
          end else if (slot_done) begin
            if (bit_r == 7'(`ID_BITS - 1)) state_r <= S_DONE;
            else begin
              bit_r <= bit_r + 7'd1;
              state_r <= S_SRCH_A;
              first_r <= 1'b1;
            end
          end
        end
        S_DONE: begin
          done_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // identity capture, crc, byte stream out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_r <= '0;
      crc_r <= '0;
      crc_ok_r <= 1'b0;
      byte_sr_r <= '0;
      push_r <= 1'b0;
    end else if (ce) begin
      if (push_r && fifo_ready) push_r <= 1'b0;
      if (state_r == S_PRES) begin
        crc_r <= '0;
        crc_ok_r <= 1'b0;
      end
      if (!stall && slot_done && (state_r == S_READ || state_r == S_SRCH_W)) begin
        // search stores the written bit, which is the found identity bit
        id_r[bit_r[5:0]] <= (state_r == S_READ) ? slot_smp_r : cur_bit;
        byte_sr_r <= {((state_r == S_READ) ? slot_smp_r : cur_bit), byte_sr_r[7:1]};
        if (bit_r[2:0] == 3'd7) push_r <= 1'b1;
        if (bit_r < 7'd56) begin
          crc_r <= crc_step(crc_r, (state_r == S_READ) ? slot_smp_r : cur_bit);
        end else if (bit_r == 7'(`ID_BITS - 1)) begin
          crc_ok_r <= (crc_r == {((state_r == S_READ) ? slot_smp_r : cur_bit),
                                 byte_sr_r[7:1]});
        end
      end
    end
  end
  // bytes wait here so a slow consumer stalls the next slot, not loses data
  sw_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_data(byte_sr_r),
    .in_valid(push_r),
    .in_ready(fifo_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .flush(1'b0)
  );
  // ==========================================================
  // checks
  a_reset_low_len: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && state_r == S_IDLE && start) |=> line_oe [*8])
    else $error("reset pulse too short");
  a_never_drive_hi: assert property (@(posedge sys_clk) disable iff (rst)
    line_out == 1'b0)
    else $error("line driven high");
  a_release_pres: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == S_PRES |-> !line_oe)
    else $error("master drives during presence");
  a_idle_release: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == S_IDLE |-> !line_oe)
    else $error("line held low while idle");
  sequence s_slot_open;
    ce && !stall && slot_go_r && !slot_busy_r;
  endsequence
  a_slot_falls: assert property (@(posedge sys_clk) disable iff (rst)
    s_slot_open |=> line_oe)
    else $error("slot without falling edge");
  a_cmd_to_data: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_CMD) ##1 (state_r == S_READ) |-> $past(bit_r) == 7'd7)
    else $error("command not eight bits");
  a_read_len: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_READ) ##1 (state_r == S_DONE) |-> $past(bit_r) == 7'd63)
    else $error("identity not 64 bits");
  a_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    done_r && ce |=> !done_r)
    else $error("done longer than a cycle");
endmodule // sw_master
`default_nettype wire

// ---- sim/sw_id_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module sw_id_slave #(
  parameter logic [63:0] ID = 64'h0
) (
  input wire logic clk,
  input wire logic en,
  input wire logic line,
  output logic pull
);
  // =========
  // timing in 100 ns ticks, picked inside the allowed windows
  localparam int RST_MIN = 1200;
  localparam int PWAIT = 300;
  localparam int PLOW = 1000;
  // late sampling point, well past a write-one low time
  localparam int TSAMP = 300;
  logic prev = 1'b1;
  int lo = 0;
  int pt = 0;
  int t = 0;
  int n = 0;
  logic [1:0] st = 2'h0;
  logic [1:0] ph = 2'h0;
  logic [7:0] cmd = 8'h00;
  logic drv0;
  // =========
  // line sensing and slot sequencing
  always @(posedge clk) begin
    prev <= line;
    lo <= line ? 0 : lo + 1;
    pt <= (pt == 0 || pt == PWAIT + PLOW) ? 0 : pt + 1;
    t <= (t == 0 || t == TSAMP) ? 0 : t + 1;
    if (en && line && !prev && lo > RST_MIN) begin
      pt <= 1;
      st <= 2'h1;
      n <= 0;
      ph <= 2'h0;
    end else if (!line && prev && !pull && st != 2'h0) begin
      t <= 1;
    end
    if (t == TSAMP) begin
      if (st == 2'h1) begin
        cmd <= {line, cmd[7:1]};
        n <= n + 1;
        if (n == 7) begin
          n <= 0;
          case ({line, cmd[7:1]})
            8'h33, 8'h0f: st <= 2'h2;
            8'hf0: st <= 2'h3;
            default: st <= 2'h0;
          endcase
        end
      end else if (st == 2'h2 || ph == 2'h2) begin
        if (st == 2'h3 && line != ID[n]) begin
          st <= 2'h0;
        end
        if (n == 63) begin
          st <= 2'h0;
        end
        n <= n + 1;
        ph <= 2'h0;
      end else begin
        ph <= ph + 2'h1;
      end
    end
  end
  // =========
  // reply bits; a one leaves the slot alone
  always_comb begin
    drv0 = 1'b0;
    if (st == 2'h2 || (st == 2'h3 && ph == 2'h0)) begin
      drv0 = !ID[n];
    end
    if (st == 2'h3 && ph == 2'h1) begin
      drv0 = ID[n];
    end
  end
  // only ever pulls low, the pullup makes the high level
  assign pull = en && ((pt > PWAIT && pt <= PWAIT + PLOW) || (t != 0 && drv0));
endmodule // sw_id_slave
`default_nettype wire

// ---- sim/sw_master_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sw_master_tb_top;
  import sw_master_pkg::*;
  // =========
  // identities; family codes are arbitrary values
  // the two family codes differ in bit 0 so a search splits at once
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    end
    return c;
  endfunction
  localparam logic [55:0] BODY_A = 56'h00_1234_5678_9a_5a;
  localparam logic [55:0] BODY_B = 56'h00_8765_4321_0b_5b;
  localparam logic [63:0] ID_A = {crc8(BODY_A), BODY_A};
  localparam logic [63:0] ID_B = {crc8(BODY_B), BODY_B};
  logic sys_clk, rst, ce, start, busy, done_r, presence_r, crc_ok_r;
  logic rx_valid, rx_ready, line_out, line_oe, line, pull_a, pull_b, en_a, en_b;
  op_t op;
  logic [63:0] search_path, id_r;
  logic [7:0] rx_data;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int oe_run = 0;
  int last_run = 0;
  int pulls = 0;
  int rises = 0;
  sw_master u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .start(start), .op(op),
    .search_path(search_path), .busy(busy), .done_r(done_r), .presence_r(presence_r),
    .crc_ok_r(crc_ok_r), .id_r(id_r), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .line_in(line), .line_out(line_out), .line_oe(line_oe));
  sw_id_slave #(.ID(ID_A)) u_slave_a (.clk(sys_clk), .en(en_a), .line(line), .pull(pull_a));
  sw_id_slave #(.ID(ID_B)) u_slave_b (.clk(sys_clk), .en(en_b), .line(line), .pull(pull_b));
  // pullup: released line reads high
  assign line = ~((line_oe & ~line_out) | pull_a | pull_b);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // =========
  // monitors and timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (line_oe === 1'b1) begin
      if (oe_run == 0) rises <= rises + 1;
      oe_run <= oe_run + 1;
    end else begin
      if (oe_run != 0) last_run <= oe_run;
      oe_run <= 0;
    end
    if ((pull_a | pull_b) && line_oe !== 1'b1) pulls <= pulls + 1;
    if (cyc == 104000) begin
      failures++;
      stop_test();
    end
  end
  // =========
  // shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic go(input op_t o, input logic ea, input logic eb);
    @(posedge sys_clk);
    en_a <= ea;
    en_b <= eb;
    op <= o;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask
  task automatic wait_done();
    int i;
    i = 0;
    #1;
    while (done_r !== 1'b1 && i < 80000) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    check(64'(done_r), 64'h1);
  endtask
  // =========
  // scenarios
  task automatic scen_no_slave();
    go(OP_RESET_ONLY, 1'b0, 1'b0);
    repeat (1000) @(posedge sys_clk);
    ce <= 1'b0;
    #1;
    check(64'(busy), 64'h1);
    check(64'(line_out), 64'h0);
    // frozen cycles stretch the reset pulse by exactly their number
    repeat (200) @(posedge sys_clk);
    ce <= 1'b1;
    wait_done();
    check(64'(busy), 64'h0);
    check(64'(last_run), 64'd5000);
    check(64'(presence_r), 64'h0);
    check(64'(line_oe), 64'h0);
  endtask
  task automatic scen_skip();
    int p0;
    p0 = pulls;
    go(OP_SKIP, 1'b1, 1'b1);
    wait_done();
    check(64'(presence_r), 64'h1);
    // a wrong code would wake a reply and add pulled cycles
    check(64'(pulls - p0), 64'd1000);
    check(64'(rx_valid), 64'h0);
  endtask
  task automatic scen_read();
    int i;
    go(OP_READ_ID, 1'b1, 1'b0);
    repeat (100) @(posedge sys_clk);
    start <= 1'b1;
    op <= OP_SKIP;
    @(posedge sys_clk);
    start <= 1'b0;
    wait_done();
    check(id_r, ID_A);
    check(64'(crc_ok_r), 64'h1);
    // consumer stalled through the whole reply, now drained
    for (int k = 0; k < 8; k++) begin
      i = 0;
      while (rx_valid !== 1'b1 && i < 100) begin
        @(posedge sys_clk);
        #1;
        i++;
      end
      check(64'(rx_data), 64'(ID_A[8*k +: 8]));
      @(posedge sys_clk);
      rx_ready <= 1'b1;
      @(posedge sys_clk);
      rx_ready <= 1'b0;
      #1;
    end
    check(64'(rx_valid), 64'h0);
  endtask
  task automatic scen_search();
    int r0;
    int i;
    r0 = rises;
    i = 0;
    @(posedge sys_clk);
    search_path <= 64'h1;
    go(OP_SEARCH, 1'b1, 1'b1);
    // slots: reset, 8 command, read, complement, write of bit 0
    while (rises - r0 < 12 && i < 20000) begin
      @(posedge sys_clk);
      i++;
    end
    // silence both: bit 1 reads high twice and the pass ends early,
    // which keeps the run short instead of walking all 64 bits
    repeat (100) @(posedge sys_clk);
    en_a <= 1'b0;
    en_b <= 1'b0;
    wait_done();
    check(64'(presence_r), 64'h1);
    check(64'(id_r[0]), 64'(ID_B[0]));
    check(64'(crc_ok_r), 64'h0);
    check(64'(rx_valid), 64'h0);
    check(64'(busy), 64'h0);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    op = OP_RESET_ONLY;
    search_path = 64'h0;
    rx_ready = 1'b0;
    en_a = 1'b0;
    en_b = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    scen_no_slave();
    scen_skip();
    scen_read();
    scen_search();
    stop_test();
  end
endmodule // sw_master_tb_top
`default_nettype wire
